// ===== src/fdcm_top.sv
// Field delay color memory: field-sequential 3-bit code in, parallel RGB code out.
// Assumes strobes from the timing unit, all aligned to i_sample_en.
// Overview of operation
// - Two cascaded one-field delay memories
// - Each code bit packed into 16-bit words
// - 2048-bit groups, 16 wide, 5:1 rotation
// - Active-line group shift rate 76.8 kHz
// - Selectors route sources to red, blue, green
// - Selected words serialised back to 3-bit streams
// - Odd and even fields align at outputs
// - 640 samples, 245 lines stored per field
// - 9800 shift pulses store one field
// - 440 refresh shifts during vertical retrace
// - Even field color sync delayed half line
// - Odd 18, even 17 retrace lines
// - Active shift sequence same both fields
// - Odd: 14 lines x20, 4 lines x40
// - Even: 12 lines x20, 5 lines x40
// - All conversion paced by sampling clock
// - First four samples per line are zero
`timescale 1ns/1ns
module fdcm_top
  import fdcm_pkg::*;
#(
  parameter int HALF_DLY = HALF_LINE,
  parameter int N_LINES  = ACTIVE_LINES
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Timing unit
  input  wire logic                 i_sample_en,
  input  wire logic                 i_line_start,
  input  wire logic                 i_active,
  input  wire logic                 i_vsync,
  input  wire logic                 i_field_odd,
  input  wire logic [1:0]           i_field_addr,
  // Coded video in
  input  wire logic [CODE_BITS-1:0] i_code,
  // Coded video out
  output logic                      o_valid,
  output logic      [CODE_BITS-1:0] o_red,
  output logic      [CODE_BITS-1:0] o_green,
  output logic      [CODE_BITS-1:0] o_blue,
  input  wire logic                 i_out_ready,
  output logic                      o_overrun
);
  localparam int BUF_W       = COLORS * WORD_W + 1;
  localparam int FIELD_WORDS = N_LINES * LINE_SAMPLES / WORD_BITS;
  // Memory sized so one field of video plus refresh fills it exactly
  localparam int MEM_DEPTH   = (FIELD_WORDS + REFRESH_SHIFTS) / GROUPS;

  initial begin
    if (HALF_DLY < 1 || HALF_DLY > 1023) begin
      $error("fdcm_top: HALF_DLY out of range");
    end
    if (N_LINES < 1 || N_LINES > ACTIVE_LINES) begin
      $error("fdcm_top: N_LINES out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_WAIT    = 3'h1,
    ST_RETRACE = 3'h2,
    ST_VIDEO   = 3'h4
  } fdcm_state_t;

  fdcm_state_t state;
  fdcm_state_t next_state;

  // Even field start held back by half a line
  logic       dly_run;
  logic [9:0] dly_cnt;
  logic       fstart;
  logic       field_odd;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dly_run <= 1'b0;
      dly_cnt <= 10'h000;
    end else if (i_vsync && !i_field_odd) begin
      dly_run <= 1'b1;
      dly_cnt <= 10'h000;
    end else if (dly_run && i_sample_en) begin
      dly_cnt <= dly_cnt + 10'h001;
      if (32'(dly_cnt) == HALF_DLY - 1) dly_run <= 1'b0;
    end
  end

  assign fstart = (i_vsync && i_field_odd) ||
                  (dly_run && i_sample_en && 32'(dly_cnt) == HALF_DLY - 1);

  always_ff @(posedge i_clk) begin
    if (i_rst) field_odd <= 1'b1;
    else if (i_vsync) field_odd <= i_field_odd;
  end

  // Retrace line bookkeeping and refresh quota
  logic [4:0] rline;
  logic [5:0] quota;
  logic       refresh_stb;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT:    if (fstart) next_state = ST_RETRACE;
      ST_RETRACE: if (i_line_start && 32'(rline) ==
                      (field_odd ? ODD_RETRACE : EVEN_RETRACE)) next_state = ST_VIDEO;
      ST_VIDEO:   if (fstart) next_state = ST_RETRACE;
      default:    next_state = ST_WAIT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) state <= ST_WAIT;
    else state <= next_state;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || fstart) begin
      rline <= 5'h00;
    end else if (state == ST_RETRACE && i_line_start) begin
      rline <= rline + 5'h01;
    end
  end

  // Short lines come first, long lines close the retrace
  always_ff @(posedge i_clk) begin
    if (i_rst || fstart) begin
      quota <= 6'h00;
    end else if (state == ST_RETRACE && next_state == ST_RETRACE && i_line_start) begin
      if (32'(rline) < (field_odd ? ODD_SHORT : EVEN_SHORT)) begin
        quota <= 6'(SHORT_CLOCKS);
      end else begin
        quota <= 6'(LONG_CLOCKS);
      end
    end else if (refresh_stb) begin
      quota <= quota - 6'h01;
    end
  end

  assign refresh_stb = state == ST_RETRACE && quota != 6'h00 && i_sample_en;

  // Serial to parallel, one register per code bit
  logic [9:0]            samp;
  logic [3:0]            bitn;
  logic [WORD_BITS-1:0]  sp [CODE_BITS];
  logic [WORD_W-1:0]     cur_word;
  logic                  word_stb;
  logic                  word_first;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_line_start) begin
      samp <= 10'h000;
      bitn <= 4'h0;
    end else if (i_sample_en && i_active && state == ST_VIDEO) begin
      samp <= samp + 10'h001;
      bitn <= bitn + 4'h1;
    end
  end

  for (genvar b = 0; b < CODE_BITS; b++) begin : g_sp
    always_ff @(posedge i_clk) begin
      if (i_sample_en && i_active) begin
        // Zero reference is forced so line starts match on every channel
        sp[b] <= {sp[b][WORD_BITS-2:0],
                  (32'(samp) < ZERO_REF) ? 1'b0 : i_code[b]};
      end
    end
    assign cur_word[b*WORD_BITS +: WORD_BITS] =
      {sp[b][WORD_BITS-2:0], (32'(samp) < ZERO_REF) ? 1'b0 : i_code[b]};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      word_stb   <= 1'b0;
      word_first <= 1'b0;
    end else begin
      word_stb   <= i_sample_en && i_active && state == ST_VIDEO && bitn == 4'hF;
      word_first <= samp == 10'(WORD_BITS - 1);
    end
  end

  logic [WORD_W-1:0] word_q;
  always_ff @(posedge i_clk) begin
    if (i_sample_en && i_active && bitn == 4'hF) word_q <= cur_word;
  end

  // Cascade: memory one shifts now, memory two one cycle later
  logic              act_p1;
  logic              act_p2;
  logic              ref_p1;
  logic              first_p1;
  logic              first_p2;
  logic [WORD_W-1:0] cur_p1;
  logic [WORD_W-1:0] cur_p2;
  logic [WORD_W-1:0] d1_word;
  logic [WORD_W-1:0] d2_word;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_p1 <= 1'b0;
      act_p2 <= 1'b0;
      ref_p1 <= 1'b0;
    end else begin
      act_p1 <= word_stb;
      act_p2 <= act_p1;
      ref_p1 <= refresh_stb;
    end
  end

  always_ff @(posedge i_clk) begin
    cur_p1   <= word_q;
    cur_p2   <= cur_p1;
    first_p1 <= word_first;
    first_p2 <= first_p1;
  end

  // Refresh shifts recirculate; surplus cells hold no picture
  fdcm_field_mem #(.DEPTH(MEM_DEPTH)) u_mem1 (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_shift(word_stb || refresh_stb),
    .i_hold (refresh_stb),
    .i_data (word_q),
    .o_data (d1_word)
  );

  fdcm_field_mem #(.DEPTH(MEM_DEPTH)) u_mem2 (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_shift(act_p1 || ref_p1),
    .i_hold (ref_p1),
    .i_data (d1_word),
    .o_data (d2_word)
  );

  // Color k was current (field_addr - k) mod 3 fields ago
  function automatic logic [1:0] fdcm_src(input logic [1:0] addr, input int k);
    logic [2:0] t;
    t = {1'b0, addr} + 3'h3 - 3'(k);
    return (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
  endfunction

  logic [BUF_W-1:0] sel;
  logic             sel_valid;
  logic             buf_ready;

  always_ff @(posedge i_clk) begin
    for (int k = 0; k < COLORS; k++) begin
      unique case (fdcm_src(i_field_addr, k))
        SRC_CUR: sel[k*WORD_W +: WORD_W] <= cur_p2;
        SRC_D1:  sel[k*WORD_W +: WORD_W] <= d1_word;
        default: sel[k*WORD_W +: WORD_W] <= d2_word;
      endcase
    end
    sel[BUF_W-1] <= first_p2;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) sel_valid <= 1'b0;
    else sel_valid <= act_p2;
  end

  // Stall downstream cannot push back on live video, so a lost word is flagged
  always_ff @(posedge i_clk) begin
    if (i_rst) o_overrun <= 1'b0;
    else if (sel_valid && !buf_ready) o_overrun <= 1'b1;
  end

  logic             q_valid;
  logic             q_take;
  logic [BUF_W-1:0] q_data;

  fdcm_skid #(.WIDTH(BUF_W)) u_buf (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_valid(sel_valid),
    .o_ready(buf_ready),
    .i_data (sel),
    .o_valid(q_valid),
    .i_ready(q_take),
    .o_data (q_data)
  );

  // Parallel to serial, one sample per strobe
  logic [WORD_W*COLORS-1:0] ps;
  logic [4:0]               left;
  logic                     ps_first;

  assign q_take = q_valid && i_sample_en && i_out_ready && left <= 5'h1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      left     <= 5'h00;
      ps_first <= 1'b0;
    end else if (i_sample_en && i_out_ready) begin
      if (q_take) begin
        ps       <= q_data[BUF_W-2:0];
        ps_first <= q_data[BUF_W-1];
        left     <= 5'(WORD_BITS);
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
      end
      if (!q_take) begin
        for (int i = 0; i < COLORS * CODE_BITS; i++) begin
          ps[i*WORD_BITS +: WORD_BITS] <= ps[i*WORD_BITS +: WORD_BITS] << 1;
        end
      end
    end
  end

  logic zero_out;
  assign zero_out = ps_first && left > 5'(WORD_BITS - ZERO_REF);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_red   <= '0;
      o_green <= '0;
      o_blue  <= '0;
    end else if (i_sample_en && i_out_ready) begin
      // Sample stands until the demodulators take it
      o_valid <= left != 5'h00;
      for (int b = 0; b < CODE_BITS; b++) begin
        o_red[b]   <= !zero_out && ps[(RED*CODE_BITS + b)*WORD_BITS + WORD_BITS-1];
        o_green[b] <= !zero_out && ps[(GREEN*CODE_BITS + b)*WORD_BITS + WORD_BITS-1];
        o_blue[b]  <= !zero_out && ps[(BLUE*CODE_BITS + b)*WORD_BITS + WORD_BITS-1];
      end
    end
  end

  // Checking helpers: per-field shift tallies
  logic [13:0] act_cnt;
  logic [9:0]  ref_cnt;
  logic        seen;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_cnt <= 14'h0000;
      ref_cnt <= 10'h000;
      seen    <= 1'b0;
    end else if (fstart) begin
      act_cnt <= 14'h0000;
      ref_cnt <= 10'h000;
      seen    <= state != ST_WAIT;
    end else begin
      act_cnt <= act_cnt + {13'h0000, word_stb};
      ref_cnt <= ref_cnt + {9'h000, refresh_stb};
    end
  end

  a_active_shifts: assert property (@(posedge i_clk) disable iff (i_rst)
    fstart && seen |-> 32'(act_cnt) == FIELD_WORDS)
    else $error("active shift count per field wrong");
  a_refresh_shifts: assert property (@(posedge i_clk) disable iff (i_rst)
    fstart && seen |-> 32'(ref_cnt) == REFRESH_SHIFTS)
    else $error("refresh shift count per field wrong");
  a_even_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    fstart && !(i_vsync && i_field_odd) |-> 32'(dly_cnt) == HALF_DLY - 1)
    else $error("even field start not delayed half a line");
  a_quota_value: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(quota) && quota > $past(quota) |->
      32'(quota) == SHORT_CLOCKS || 32'(quota) == LONG_CLOCKS)
    else $error("refresh quota not 20 or 40");
  a_word_pack: assert property (@(posedge i_clk) disable iff (i_rst)
    word_stb |-> $past(bitn) == 4'hF && $past(i_sample_en))
    else $error("word stored before 16 samples");
  a_cascade_step: assert property (@(posedge i_clk) disable iff (i_rst)
    word_stb |=> act_p1 ##1 act_p2 ##1 sel_valid)
    else $error("cascade pipeline out of step");
  a_zero_ref: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(zero_out) && $past(i_sample_en) && $past(i_out_ready) && !$past(i_rst) |->
      o_red == '0 && o_green == '0 && o_blue == '0)
    else $error("zero reference not forced");
  a_no_shift_video: assert property (@(posedge i_clk) disable iff (i_rst)
    refresh_stb |-> state == ST_RETRACE && !word_stb)
    else $error("refresh shift during active video");
endmodule

// ===== src/fdcm_pkg.sv
// Shared constants of the field delay color memory.
// Assumes a sampling strobe and line/field timing from the sync unit.
package fdcm_pkg;
  localparam int CODE_BITS      = 3;
  localparam int WORD_BITS      = 16;
  localparam int COLORS         = 3;
  localparam int GROUPS         = 5;
  localparam int GROUP_DEPTH    = 2048;
  localparam int LINE_SAMPLES   = 640;
  localparam int ACTIVE_LINES   = 245;
  localparam int ACTIVE_SHIFTS  = LINE_SAMPLES * ACTIVE_LINES / WORD_BITS;
  localparam int REFRESH_SHIFTS = 440;
  localparam int ODD_RETRACE    = 18;
  localparam int EVEN_RETRACE   = 17;
  localparam int ODD_SHORT      = 14;
  localparam int EVEN_SHORT     = 12;
  localparam int SHORT_CLOCKS   = 20;
  localparam int LONG_CLOCKS    = 40;
  localparam int ZERO_REF       = 4;
  localparam int TOTAL_SAMPLES  = 772;
  localparam int HALF_LINE      = TOTAL_SAMPLES / 2;
  localparam int FRAME_LINES    = 525;
  localparam int CLK_HZ         = 25_000_000;
  localparam int SAMPLE_HZ      = 12_270_000;
  localparam int SHIFT_HZ       = 76_800;
  localparam int WORD_W         = CODE_BITS * WORD_BITS;
  // Source index: 0 current, 1 one field old, 2 two fields old
  localparam logic [1:0] SRC_CUR = 2'h0;
  localparam logic [1:0] SRC_D1  = 2'h1;
  localparam logic [1:0] SRC_D2  = 2'h2;
  // Color slots in the combined word
  localparam int RED   = 0;
  localparam int GREEN = 1;
  localparam int BLUE  = 2;
endpackage

// ===== src/fdcm_field_mem.sv
// One field delay memory: a word store walked by a pointer.
// Assumes exactly GROUPS*DEPTH shift pulses per field.
`timescale 1ns/1ns
module fdcm_field_mem
  import fdcm_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int NGRP  = GROUPS,
  parameter int DEPTH = GROUP_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Shift port
  input  wire logic             i_shift,
  input  wire logic             i_hold,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(NGRP * DEPTH);

  initial begin
    if (NGRP < 2 || DEPTH < 2 || WIDTH < 1) begin
      $error("fdcm_field_mem: bad geometry");
    end
  end

  logic [WIDTH-1:0]          mem [NGRP*DEPTH];
  logic [$clog2(NGRP)-1:0]   grp;
  logic [$clog2(DEPTH)-1:0]  pos;
  logic [AW-1:0]             addr;

  // Words rotate across groups so each group shifts at a fifth of the word rate
  assign addr = AW'(pos) * AW'(NGRP) + AW'(grp);

  always_ff @(posedge i_clk) begin
    if (i_shift) begin
      o_data <= mem[addr];
      if (!i_hold) begin
        mem[addr] <= i_data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      grp <= '0;
      pos <= '0;
    end else if (i_shift) begin
      if (32'(grp) == NGRP - 1) begin
        grp <= '0;
        pos <= (32'(pos) == DEPTH - 1) ? '0 : pos + 1'b1;
      end else begin
        grp <= grp + 1'b1;
      end
    end
  end

  a_group_rotate: assert property (@(posedge i_clk) disable iff (i_rst)
    i_shift && 32'(grp) < NGRP - 1 |=> grp == $past(grp) + 1'b1 && pos == $past(pos))
    else $error("group rotation broken");
endmodule

// ===== src/fdcm_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes the drain may stall at any time.
`timescale 1ns/1ns
module fdcm_skid #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] slot [2];
  logic             rd;
  logic             wr;
  logic [1:0]       cnt;
  logic             push;
  logic             pop;

  initial begin
    if (WIDTH < 1) begin
      $error("fdcm_skid: bad width");
    end
  end

  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_ready = cnt != 2'h2;
  assign o_valid = cnt != 2'h0;
  assign o_data  = slot[rd];

  always_ff @(posedge i_clk) begin
    if (push) begin
      slot[wr] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd  <= 1'b0;
      wr  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wr <= ~wr;
      if (pop) rd <= ~rd;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  a_no_overfill: assert property (@(posedge i_clk) disable iff (i_rst)
    cnt == 2'h2 && !pop |=> cnt == 2'h2 && $stable(wr))
    else $error("buffer written while full");
endmodule

// ===== tb/fdcm_sink.sv
// Demodulator-side model: accepts the three serial streams, stalling briefly.
// Assumes ready is only looked at on sampling strobes; a hold input forces a long stall.
`timescale 1ns/1ns
module fdcm_sink (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Stream control
  input  wire logic i_hold,
  output logic      o_ready
);
  logic [6:0] cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt     <= 7'h00;
      o_ready <= 1'b1;
    end else begin
      cnt     <= (cnt == 7'h60) ? 7'h00 : cnt + 7'h01;
      // Short stalls only: the backlog built during live video drains only in blanking
      o_ready <= !i_hold && (cnt > 7'h02);
    end
  end
endmodule

// ===== tb/fdcm_bench.sv
// Bench for the field delay color memory: shortened odd field, part of an even one, restart.
// Assumes strobes every cycle except line-start and vsync cycles, in place of the sampling rate, to keep the run short.
`timescale 1ns/1ns
module fdcm_bench;
  import fdcm_pkg::*;
  localparam int HDLY  = 8;
  localparam int BLANK = 32;
  localparam int LIM   = 4000;
  // Fewer lines per field keep the run short; memory depth follows
  localparam int NLINES = 100;

  logic                 i_clk        = 1'b0;
  logic                 i_rst        = 1'b1;
  logic                 i_sample_en  = 1'b0;
  logic                 i_line_start = 1'b0;
  logic                 i_active     = 1'b0;
  logic                 i_vsync      = 1'b0;
  logic                 i_field_odd  = 1'b0;
  logic [1:0]           i_field_addr = 2'h0;
  logic [CODE_BITS-1:0] i_code       = 3'h0;
  logic                 hold         = 1'b0;
  logic                 phase2       = 1'b0;
  logic                 phase3       = 1'b0;
  logic                 chk_on       = 1'b0;
  logic                 i_out_ready;
  logic                 o_valid;
  logic                 o_overrun;
  logic [CODE_BITS-1:0] o_red;
  logic [CODE_BITS-1:0] o_green;
  logic [CODE_BITS-1:0] o_blue;
  logic [31:0]          e_r;
  logic [31:0]          e_g;
  logic [31:0]          seed         = 32'h914C;
  logic [2:0]           q_r1[$];
  logic [2:0]           q_r2[$];
  logic [2:0]           q_g[$];
  logic [2:0]           q_b[$];
  int                   n_errors     = 0;
  int                   num_checks   = 0;

  always #20 i_clk = ~i_clk;

  fdcm_top #(.HALF_DLY(HDLY), .N_LINES(NLINES)) u_dut (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_sample_en  (i_sample_en),
    .i_line_start (i_line_start),
    .i_active     (i_active),
    .i_vsync      (i_vsync),
    .i_field_odd  (i_field_odd),
    .i_field_addr (i_field_addr),
    .i_code       (i_code),
    .o_valid      (o_valid),
    .o_red        (o_red),
    .o_green      (o_green),
    .o_blue       (o_blue),
    .i_out_ready  (i_out_ready),
    .o_overrun    (o_overrun)
  );

  fdcm_sink u_sink (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_hold  (hold),
    .o_ready (i_out_ready)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One line: start pulse without strobe, then strobes; active lines note expectations
  task automatic line(input bit act);
    logic [2:0] v;
    @(posedge i_clk);
    i_line_start <= 1'b1;
    i_sample_en  <= 1'b0;
    i_active     <= 1'b0;
    for (int i = 0; i < (act ? LINE_SAMPLES + BLANK : 48); i++) begin
      @(posedge i_clk);
      seed = lfsr(seed);
      v = (act && i < ZERO_REF) ? 3'h0 : seed[2:0];
      i_line_start <= 1'b0;
      i_sample_en  <= 1'b1;
      i_active     <= act && (i < LINE_SAMPLES);
      i_code       <= v;
      if (act && i < LINE_SAMPLES) begin
        if (phase3) begin
          q_b.push_back(v);
        end else if (phase2) begin
          q_g.push_back(v);
        end else begin
          q_r1.push_back(v);
          q_r2.push_back(v);
        end
      end
    end
  endtask

  task automatic field(input bit odd, input logic [1:0] addr, input int nact);
    @(posedge i_clk);
    i_vsync      <= 1'b1;
    i_field_odd  <= odd;
    i_field_addr <= addr;
    i_sample_en  <= 1'b0;
    i_active     <= 1'b0;
    @(posedge i_clk);
    i_vsync     <= 1'b0;
    i_sample_en <= 1'b1;
    // Even field storage starts half a line late; wait past it before counting lines
    repeat (HDLY + 2) @(posedge i_clk);
    for (int n = 0; n < (odd ? ODD_RETRACE : EVEN_RETRACE); n++) line(1'b0);
    for (int n = 0; n < nact; n++) line(1'b1);
  endtask

  // Strobes keep running here so the serialiser can drain
  task automatic wait_drain();
    int k;
    for (k = 0; k < LIM && (q_r1.size() + q_g.size() + q_b.size()) > 0; k++) begin
      @(posedge i_clk);
    end
    if (k == LIM) begin
      check(q_r1.size() + q_g.size() + q_b.size(), 0);
      end_of_test();
    end
  endtask

  // Each strobe with ready consumes the sample presented before that edge
  always @(posedge i_clk) begin
    if (chk_on && i_sample_en && i_out_ready && o_valid === 1'b1) begin
      // An empty queue expects a value no 3-bit output can match
      if (phase3) begin
        e_g = (q_b.size() > 0) ? q_b.pop_front() : 32'hFFFF_FFFF;
        check(o_blue, e_g);
      end else if (!phase2) begin
        e_r = (q_r1.size() > 0) ? q_r1.pop_front() : 32'hFFFF_FFFF;
        check(o_red, e_r);
      end else begin
        e_r = (q_r2.size() > 0) ? q_r2.pop_front() : 32'hFFFF_FFFF;
        e_g = (q_g.size() > 0) ? q_g.pop_front() : 32'hFFFF_FFFF;
        check(o_red, e_r);
        check(o_green, e_g);
      end
    end
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst  <= 1'b0;
    chk_on <= 1'b1;
    // Red takes current data when the field address is 0
    field(1'b1, 2'h0, NLINES);
    wait_drain();
    $display("Test current odd field done");
    phase2 = 1'b1;
    // Address 1: red from one field back, green current
    field(1'b0, 2'h1, 4);
    wait_drain();
    check(q_r2.size(), (NLINES - 4) * LINE_SAMPLES);
    $display("Test delayed even field done");
    chk_on <= 1'b0;
    hold   <= 1'b1;
    line(1'b1);
    line(1'b1);
    @(negedge i_clk);
    check(o_overrun, 1);
    @(posedge i_clk);
    hold  <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    check(o_overrun, 0);
    check(o_valid, 0);
    $display("Test overrun and reset done");
    // Fresh start at address 2: blue takes current data
    q_g.delete();
    phase3 = 1'b1;
    @(posedge i_clk);
    i_rst  <= 1'b0;
    chk_on <= 1'b1;
    field(1'b1, 2'h2, 2);
    wait_drain();
    $display("Test blue current field done");
    end_of_test();
  end
endmodule
